/* File: rtl/sic_pkg.sv */
package sic_pkg;
  // ==========================================
  // Register map (word offsets, byte addresses)
  localparam logic [7:0] SIC_OFF_SAVE = 8'h00;
  localparam logic [7:0] SIC_OFF_MODE = 8'h04;
  localparam logic [7:0] SIC_OFF_FILT = 8'h08;
  localparam logic [7:0] SIC_OFF_LOOP = 8'h0C;
  localparam logic [7:0] SIC_OFF_STAT = 8'h10;
  localparam logic [7:0] SIC_OFF_CAUSE = 8'h14;
  // ==========================================
  // Field positions
  localparam int SIC_SAVE_NMASK0 = 0;
  localparam int SIC_SAVE_NMASK1 = 1;
  localparam int SIC_SAVE_IMASK = 2;
  localparam int SIC_SAVE_TRIG = 3;
  localparam int SIC_FILT_EN = 3;
  localparam int SIC_CAUSE_UV = 0;
  localparam int SIC_CAUSE_CSTOP = 1;
  localparam int SIC_CAUSE_WDT = 4;
  localparam int SIC_CAUSE_PIN = 5;
  localparam int SIC_CAUSE_POWER = 6;
  localparam int SIC_CAUSE_EMERG = 7;
  // ==========================================
  // Reset values and codes
  localparam logic [1:0] SIC_MODE_SUBIDLE = 2'h2;
  localparam logic [2:0] SIC_FILT_SLOW_MIN = 3'h2;
  localparam logic [7:0] SIC_SAVE_RESET = 8'h00;
  localparam logic [7:0] SIC_CAUSE_RESET = 8'h00;
  // ==========================================
  // Timing
  localparam int SIC_WAKE_SUB_CYCLES = 12;
  localparam int SIC_WAKE_US = 366;
  localparam logic [3:0] SIC_WAKE_COUNT = 4'(SIC_WAKE_SUB_CYCLES);
  localparam int SIC_STAB_CYCLES = 1024;

  typedef enum logic [1:0] {
    SIC_RUN = 2'b00,
    SIC_IDLE = 2'b01,
    SIC_WAKE = 2'b10
  } sic_state_t;
endpackage

/* File: rtl/sic_wake_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module sic_wake_timer
  import sic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic sub_tick,
  // Result
  output logic done
);
  typedef struct packed {
    logic busy;
    logic [3:0] cnt;
    logic done;
  } sic_wt_t;
  sic_wt_t q, next_q;

  // ==========================================
  // Subclock cycle counter
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (start && !q.busy) begin
      next_q.busy = 1'b1;
      next_q.cnt = 4'h0;
    end else if (q.busy && sub_tick) begin
      if (q.cnt == SIC_WAKE_COUNT - 4'h1) begin // see R03
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
      end else begin
        next_q.cnt = q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done = q.done;
endmodule
`default_nettype wire

/* File: rtl/sic_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// Operation
// R01: Any NMI or unmasked maskable request wakes sub-idle regardless of priority.
// R02: Requests with wake mask bit set to 1 do not end sub-idle.
// R03: Exit completes 12 subclock cycles after the releasing request, about 366 us.
// R04: Pin 3 with slow noise filter sampling cannot wake from sub-idle.
// R05: Lower-priority request wakes but is not acknowledged; it stays pending.
// R06: Higher-priority or NMI request wakes and is acknowledged.
// R07: After NMI wake, CPU branches to handler regardless of enable state.
// R08: Maskable wake with interrupts disabled resumes at next instruction.
// R09: Reset during sub-idle performs the ordinary reset sequence.
// R10: CPU, timers and interrupt controller stop except wake path.
// R11: Serial units stop; unit 0 runs when on its external clock.
// R12: Converter control holds operation and keeps its last result.
// R13: Ports and all processor state and RAM are retained.
// R14: Software should stop the converter before sub-idle for lowest power.
// R15: Multiplier loop off while main clock stopped; software clears enable first.
// R16: Accept five reset sources and record the cause for software.
// R17: Watchdog overflow in stabilisation wait starts CPU on internal oscillator.
// R18: Software avoids wait-state registers while on internal oscillator.
// R19: Mode field 10 then trigger bit 1 enters sub-idle from subclock mode.
// R20: Interrupt wake returns to subclock mode, loop restores previous state.
// R21: Pending unmasked request at entry causes immediate exit.
// R22: Wake counter starts at synced request rise; clocks restart at count end.
module sic_ctrl
  import sic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock context
  input wire logic sub_tick,
  input wire logic on_subclock,
  input wire logic main_osc_stopped,
  input wire logic ser0_ext_clock,
  // Wake sources
  input wire logic nmi_req,
  input wire logic wdt_nmi_req,
  input wire logic irq_req,
  input wire logic irq_is_pin3,
  input wire logic irq_higher_prio,
  input wire logic in_handler,
  input wire logic irq_enabled,
  // Reset sources
  input wire logic pin_reset,
  input wire logic watchdog_two_reset,
  input wire logic undervoltage_reset,
  input wire logic clock_stop_reset,
  input wire logic power_on_reset,
  input wire logic stab_wait,
  input wire logic watchdog_two_ovf,
  // Outputs to the chip
  output logic cpu_clock_run,
  output logic timers_run,
  output logic intc_run,
  output logic ser0_run,
  output logic ser1_run,
  output logic adc_hold,
  output logic port_hold,
  output logic multiplier_loop_on,
  output logic irq_ack,
  output logic take_handler,
  output logic use_internal_osc,
  output logic in_sub_idle
);
  typedef struct packed {
    sic_state_t st;
    logic [7:0] save;
    logic [1:0] mode;
    logic [3:0] filt;
    logic loop_en;
    logic loop_saved;
    logic [7:0] cause;
    logic emerg;
    logic wake_nmi;
    logic req_d;
    logic ph_w;
    logic ph_r;
    logic [7:0] ph_a;
    logic [31:0] rdata;
    logic ack;
    logic handler;
    logic [10:0] stab_cnt;
  } sic_ctrl_s_t;
  sic_ctrl_s_t q, next_q;
  logic wake_done;
  logic nmi_wake, mi_wake, any_wake, wake_start;

  function automatic logic [31:0] sic_read(input sic_ctrl_s_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      SIC_OFF_SAVE: v = {24'h00_0000, s.save};
      SIC_OFF_MODE: v = {30'h0000_0000, s.mode};
      SIC_OFF_FILT: v = {28'h000_0000, s.filt};
      SIC_OFF_LOOP: v = {31'h0000_0000, s.loop_en};
      SIC_OFF_STAT: v = {28'h000_0000, s.emerg, s.wake_nmi, s.st};
      SIC_OFF_CAUSE: v = {24'h00_0000, s.cause};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ==========================================
  // Wake qualification
  always_comb begin
    // NMI sources with their own masks; priority never considered
    nmi_wake = (nmi_req && !q.save[SIC_SAVE_NMASK0])
      || (wdt_nmi_req && !q.save[SIC_SAVE_NMASK1]); // see R01, R02
    // Slow filter sampling blocks pin 3 since its clock is gone
    mi_wake = irq_req && !q.save[SIC_SAVE_IMASK]
      && !(irq_is_pin3 && q.filt[SIC_FILT_EN] && q.filt[2:0] >= SIC_FILT_SLOW_MIN); // see R04
    any_wake = nmi_wake || mi_wake;
    wake_start = any_wake && !q.req_d; // see R22
  end

  sic_wake_timer u_timer (
    .clk(clk),
    .rst(rst),
    .start(q.st == SIC_WAKE && wake_start),
    .sub_tick(sub_tick),
    .done(wake_done)
  );

  // ==========================================
  // Next state
  always_comb begin
    next_q = q;
    next_q.ack = 1'b0;
    next_q.handler = 1'b0;
    next_q.req_d = any_wake;
    next_q.ph_w = 1'b0;
    next_q.ph_r = 1'b0;
    // Bus data phase
    if (q.ph_w) begin
      case (q.ph_a)
        SIC_OFF_SAVE: next_q.save = hwdata[7:0];
        SIC_OFF_MODE: next_q.mode = hwdata[1:0];
        SIC_OFF_FILT: next_q.filt = hwdata[3:0];
        SIC_OFF_LOOP: next_q.loop_en = hwdata[0];
        SIC_OFF_CAUSE: next_q.cause = q.cause & hwdata[7:0];
        default: next_q.loop_en = q.loop_en;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      next_q.ph_w = hwrite;
      next_q.ph_r = !hwrite;
      next_q.ph_a = haddr[7:0];
      // Read sees a write landing in this same cycle
      next_q.rdata = sic_read(next_q, haddr[7:0]);
    end
    // Standby sequencing
    case (q.st)
      SIC_RUN: begin
        if (q.ph_w && q.ph_a == SIC_OFF_SAVE && hwdata[SIC_SAVE_TRIG] && on_subclock
            && q.mode == SIC_MODE_SUBIDLE) begin // see R19
          next_q.loop_saved = q.loop_en;
          next_q.save[SIC_SAVE_TRIG] = 1'b0;
          // A request already high never shows a rising edge
          if (any_wake) begin
            next_q.st = SIC_WAKE; // see R21
            next_q.req_d = 1'b0;
          end else begin
            next_q.st = SIC_IDLE;
          end
        end
      end
      SIC_IDLE: begin
        if (any_wake) begin
          next_q.st = SIC_WAKE; // see R01
          next_q.req_d = 1'b0;
        end
      end
      SIC_WAKE: begin
        if (wake_done) begin
          next_q.st = SIC_RUN; // see R20, R22
          next_q.loop_en = q.loop_saved;
          next_q.wake_nmi = nmi_wake;
          // NMI always taken; maskable only if enabled and outranking
          if (nmi_wake) begin
            next_q.ack = 1'b1; // see R06, R07
            next_q.handler = 1'b1;
          end else if (irq_enabled && (!in_handler || irq_higher_prio)) begin
            next_q.ack = 1'b1; // see R06, R08
            next_q.handler = 1'b1;
          end
          // Lower priority or disabled: no ack, request stays pending
        end
      end
      default: next_q.st = SIC_RUN;
    endcase
    // Loop cannot run without main clock
    if (main_osc_stopped) begin
      next_q.loop_en = 1'b0; // see R15
    end
    // Emergency fallback while waiting for the oscillator
    if (stab_wait) begin
      if (q.stab_cnt != 11'(SIC_STAB_CYCLES)) begin
        next_q.stab_cnt = q.stab_cnt + 11'h001;
      end
      if (watchdog_two_ovf) begin
        next_q.emerg = 1'b1; // see R17
        next_q.cause[SIC_CAUSE_EMERG] = 1'b1;
      end
    end
  end

  // ==========================================
  // Registers; any reset source runs the normal reset, idle or not
  logic any_reset;
  assign any_reset = pin_reset || watchdog_two_reset || undervoltage_reset
    || clock_stop_reset || power_on_reset; // see R09, R16

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (any_reset) begin
      q <= '0;
      // Cause kept so software can read it after release
      q.cause[SIC_CAUSE_UV] <= undervoltage_reset || q.cause[SIC_CAUSE_UV]; // see R16
      q.cause[SIC_CAUSE_CSTOP] <= clock_stop_reset || q.cause[SIC_CAUSE_CSTOP];
      q.cause[SIC_CAUSE_WDT] <= watchdog_two_reset || q.cause[SIC_CAUSE_WDT];
      q.cause[SIC_CAUSE_PIN] <= pin_reset;
      q.cause[SIC_CAUSE_POWER] <= power_on_reset;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================
  // Outputs
  logic idle_q;
  typedef struct packed {
    logic [31:0] rd;
    logic cpu, tmr, intc, s0, s1, adc, port, loop, ack, hnd, osc, idle;
  } sic_out_t;
  sic_out_t o, next_o;
  always_comb begin
    idle_q = (next_q.st != SIC_RUN);
    next_o.rd = next_q.rdata;
    next_o.cpu = !idle_q; // see R10
    next_o.tmr = !idle_q;
    next_o.intc = !idle_q;
    next_o.s0 = !idle_q || ser0_ext_clock; // see R11
    next_o.s1 = !idle_q;
    next_o.adc = idle_q; // see R12
    next_o.port = idle_q; // see R13
    next_o.loop = next_q.loop_en && !main_osc_stopped; // see R15
    next_o.ack = next_q.ack; // see R05
    next_o.hnd = next_q.handler;
    next_o.osc = next_q.emerg;
    next_o.idle = idle_q;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      o <= '0;
      o.cpu <= 1'b1;
      o.tmr <= 1'b1;
      o.intc <= 1'b1;
      o.s0 <= 1'b1;
      o.s1 <= 1'b1;
    end else begin
      o <= next_o;
    end
  end

  assign hrdata = o.rd;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cpu_clock_run = o.cpu;
  assign timers_run = o.tmr;
  assign intc_run = o.intc;
  assign ser0_run = o.s0;
  assign ser1_run = o.s1;
  assign adc_hold = o.adc;
  assign port_hold = o.port;
  assign multiplier_loop_on = o.loop;
  assign irq_ack = o.ack;
  assign take_handler = o.hnd;
  assign use_internal_osc = o.osc;
  assign in_sub_idle = o.idle;
endmodule
`default_nettype wire

/* File: test/sic_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module sic_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs watched
  input wire logic sub_tick, nmi_req, wdt_nmi_req, irq_enabled, pin_reset,
  input wire logic stab_wait, watchdog_two_ovf, main_osc_stopped, ser0_ext_clock,
  // Outputs watched
  input wire logic cpu_clock_run, timers_run, intc_run, ser0_run, ser1_run,
  input wire logic adc_hold, port_hold, multiplier_loop_on, take_handler,
  input wire logic use_internal_osc, in_sub_idle
);
  // ==========================================
  // Subclock ticks seen since entry
  logic [4:0] ticks;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ticks <= 5'h00;
    end else if (!in_sub_idle) begin
      ticks <= 5'h00;
    end else if (sub_tick && ticks != 5'h1F) begin
      ticks <= ticks + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Properties
  AST_IDLE_STOP: assert property (in_sub_idle |-> !cpu_clock_run && !timers_run && !intc_run
    && !ser1_run) else $error("unit runs in sub-idle");
  AST_SER0_EXT: assert property (in_sub_idle && $past(in_sub_idle) && $stable(ser0_ext_clock)
    |-> ser0_run == ser0_ext_clock) else $error("serial 0 run wrong");
  AST_HOLD: assert property (in_sub_idle |-> adc_hold && port_hold)
    else $error("hold missing in sub-idle");
  AST_LOOP_OFF: assert property (main_osc_stopped && $past(main_osc_stopped)
    |-> !multiplier_loop_on) else $error("loop on without main clock");
  // Pin reset exits are excluded: they may end the state at any time
  AST_WAKE_LAT: assert property ($fell(in_sub_idle) && !$past(pin_reset) && !$past(pin_reset, 2)
    |-> ticks >= 5'h0C) else $error("wake too early");
  AST_WAKE_RUN: assert property ($fell(in_sub_idle) && !$past(pin_reset) |-> cpu_clock_run
    && timers_run) else $error("no return to run");
  AST_NMI_BRANCH: assert property ($fell(in_sub_idle) && !$past(pin_reset)
    && $past(nmi_req | wdt_nmi_req, 2) |-> (take_handler || $past(take_handler))
    or (##1 take_handler)) else $error("no branch after nmi wake");
  AST_DI_RESUME: assert property ($fell(in_sub_idle) && !$past(pin_reset)
    && !$past(nmi_req | wdt_nmi_req, 2) && !$past(irq_enabled)
    |-> !take_handler [*3]) else $error("branch while disabled");
  AST_EMERG: assert property (stab_wait && watchdog_two_ovf |-> ##[1:3] use_internal_osc)
    else $error("no internal oscillator fallback");
  AST_PIN_RESET: assert property (pin_reset |-> ##[0:2] !in_sub_idle)
    else $error("reset did not end sub-idle");
endmodule
bind sic_ctrl sic_monitor mon (.clk, .rst, .sub_tick, .nmi_req, .wdt_nmi_req, .irq_enabled,
  .pin_reset, .stab_wait, .watchdog_two_ovf, .main_osc_stopped, .ser0_ext_clock,
  .cpu_clock_run, .timers_run, .intc_run, .ser0_run, .ser1_run, .adc_hold, .port_hold,
  .multiplier_loop_on, .take_handler, .use_internal_osc, .in_sub_idle);
`default_nettype wire

/* File: test/sic_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module sic_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control: nmi, watchdog nmi, maskable
  input wire logic [2:0] raise,
  input wire logic clr,
  // Answers from the block
  input wire logic irq_ack,
  input wire logic take_handler,
  // Requests and subclock
  output logic sub_tick,
  output logic nmi_req,
  output logic wdt_nmi_req,
  output logic irq_req
);
  logic [2:0] div;
  logic [2:0] req;
  // Subclock shrunk to clk/8 to keep the run short
  assign sub_tick = (div == 3'h7);
  assign {irq_req, wdt_nmi_req, nmi_req} = req;
  // Requests stay up until served; an unserved one is kept pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 3'h0;
      req <= 3'h0;
    end else begin
      div <= div + 3'h1;
      if (clr) begin
        req <= 3'h0;
      end else begin
        req <= (req | raise) & ~{irq_ack, take_handler, take_handler};
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sic_pkg::*;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, clr = 0, hresp, hreadyout;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, seed = 32'h60762D22;
  logic [1:0] htrans = 0;
  logic [2:0] raise = 0;
  logic [3:0] rsrc = 0;
  logic on_subclock = 1, main_osc_stopped = 0, ser0_ext_clock = 0, irq_is_pin3 = 0;
  logic irq_higher_prio = 0, in_handler = 0, irq_enabled = 0, pin_reset = 0, stab_wait = 0;
  logic watchdog_two_ovf = 0, sub_tick, nmi_req, wdt_nmi_req, irq_req, seen_ack, seen_hd;
  logic cpu_clock_run, timers_run, intc_run, ser0_run, ser1_run, adc_hold, port_hold;
  logic multiplier_loop_on, irq_ack, take_handler, use_internal_osc, in_sub_idle;
  int num_errors = 0, n_compared = 0;
  int pos[4] = '{SIC_CAUSE_WDT, SIC_CAUSE_UV, SIC_CAUSE_CSTOP, SIC_CAUSE_POWER};
  always #2 clk = ~clk;
  sic_ctrl uut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sub_tick, .on_subclock,
    .main_osc_stopped, .ser0_ext_clock, .nmi_req, .wdt_nmi_req, .irq_req, .irq_is_pin3,
    .irq_higher_prio, .in_handler, .irq_enabled, .pin_reset, .watchdog_two_reset(rsrc[0]),
    .undervoltage_reset(rsrc[1]), .clock_stop_reset(rsrc[2]), .power_on_reset(rsrc[3]),
    .stab_wait, .watchdog_two_ovf, .cpu_clock_run, .timers_run, .intc_run, .ser0_run,
    .ser1_run, .adc_hold, .port_hold, .multiplier_loop_on, .irq_ack, .take_handler,
    .use_internal_osc, .in_sub_idle);
  sic_partner far (.clk, .rst, .raise, .clr, .irq_ack, .take_handler, .sub_tick, .nmi_req,
    .wdt_nmi_req, .irq_req);
  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Zero-wait registers only, safe on any clock source
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic enter(input logic [2:0] mask);
    // Converter taken as already stopped by software
    bus(1'b1, SIC_OFF_MODE, {30'h0, SIC_MODE_SUBIDLE});
    bus(1'b1, SIC_OFF_SAVE, {28'h0, 1'b1, mask});
    repeat (2) @(posedge clk);
    chk("idle", in_sub_idle, 1'b1);
  endtask
  task automatic wake(input logic [2:0] k);
    seen_ack = 0; seen_hd = 0;
    raise <= k; @(posedge clk); raise <= 3'h0;
    repeat (150) begin
      @(negedge clk); seen_ack |= irq_ack; seen_hd |= take_handler;
    end
    @(posedge clk); clr <= 1'b1; @(posedge clk); clr <= 1'b0;
  endtask
  task automatic pin_rst;
    pin_reset <= 1'b1; @(posedge clk); pin_reset <= 1'b0; repeat (2) @(posedge clk);
    chk("exit", in_sub_idle, 1'b0);
    chk("cpu", cpu_clock_run, 1'b1);
  endtask
  task automatic close_out;
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0; @(posedge clk);
    bus(1'b0, SIC_OFF_SAVE, 0); chk("save_ctrl", q, {24'h0, SIC_SAVE_RESET});
    bus(1'b0, 8'h40, 0); chk("unmapped", q, 0);
    bus(1'b1, SIC_OFF_LOOP, 32'h1);
    for (int k = 0; k < 2; k++) begin
      enter(3'h0); wake(3'(1 << k)); chk("exit", in_sub_idle, 1'b0);
      chk("handler", seen_hd, 1'b1);
      chk("loop", multiplier_loop_on, 1'b1);
    end
    enter(3'h7); wake(3'h7); chk("masked", in_sub_idle, 1'b1);
    pin_rst(); bus(1'b0, SIC_OFF_CAUSE, 0); chk("cause", q[SIC_CAUSE_PIN], 1'b1);
    irq_is_pin3 <= 1'b1; bus(1'b1, SIC_OFF_FILT, 32'hB);
    enter(3'h0); wake(3'h4); chk("pin3", in_sub_idle, 1'b1);
    pin_rst(); bus(1'b1, SIC_OFF_FILT, 32'h9);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      {irq_is_pin3, irq_enabled, in_handler, irq_higher_prio, ser0_ext_clock} <= seed[4:0];
      enter(3'h0); wake(3'h4); chk("exit", in_sub_idle, 1'b0);
      chk("ack", seen_ack, seed[3] && (!seed[2] || seed[1]));
      if (!seed[3]) chk("handler", seen_hd, 1'b0);
    end
    raise <= 3'h4; @(posedge clk); raise <= 3'h0;
    enter(3'h0); wake(3'h0); chk("pending", in_sub_idle, 1'b0);
    bus(1'b1, SIC_OFF_LOOP, 0); main_osc_stopped <= 1'b1;
    repeat (2) @(posedge clk); chk("loop", multiplier_loop_on, 1'b0);
    bus(1'b1, SIC_OFF_LOOP, 32'h1);
    repeat (2) @(posedge clk); chk("loop_stopped", multiplier_loop_on, 1'b0);
    main_osc_stopped <= 1'b0; stab_wait <= 1'b1; watchdog_two_ovf <= 1'b1;
    @(posedge clk); watchdog_two_ovf <= 1'b0; stab_wait <= 1'b0;
    repeat (3) @(posedge clk); chk("emerg", use_internal_osc, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rsrc <= 4'(1 << i); @(posedge clk); rsrc <= 4'h0; repeat (2) @(posedge clk);
      bus(1'b0, SIC_OFF_CAUSE, 0); chk("cause", q[pos[i]], 1'b1);
    end
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
